//--- rtl/pgowm_defs.svh
// Register offsets, field positions, reset values and codes of the pulse timer
`ifndef PGOWM_DEFS_SVH
`define PGOWM_DEFS_SVH

`define PGOWM_ADDR_W 12

`define PGOWM_OFF_MODE 12'h000
`define PGOWM_OFF_CCC 12'h004
`define PGOWM_OFF_TOC 12'h008
`define PGOWM_OFF_PRM 12'h00C
`define PGOWM_OFF_CNT 12'h010
`define PGOWM_OFF_CRA 12'h014
`define PGOWM_OFF_CRB 12'h018

`define PGOWM_MODE_OVF 0
`define PGOWM_MODE_LO 2
`define PGOWM_MODE_HI 3

`define PGOWM_CCC_CRA_CAP 0
`define PGOWM_CCC_CRA_SEL 1
`define PGOWM_CCC_CRB_CAP 2
`define PGOWM_CCC_HI 2

`define PGOWM_TOC_OE 0
`define PGOWM_TOC_TOG_A 1
`define PGOWM_TOC_LVR 2
`define PGOWM_TOC_LVS 3
`define PGOWM_TOC_TOG_B 4
`define PGOWM_TOC_OS_EN 5
`define PGOWM_TOC_OS_TRIG 6

`define PGOWM_PRM_ESA_LO 0
`define PGOWM_PRM_ESA_HI 1
`define PGOWM_PRM_ESB_LO 2
`define PGOWM_PRM_ESB_HI 3
`define PGOWM_PRM_PS_LO 4
`define PGOWM_PRM_PS_HI 5

`define PGOWM_EDGE_FALL 2'h0
`define PGOWM_EDGE_RISE 2'h1
`define PGOWM_EDGE_BOTH 2'h3

`define PGOWM_CNT_MAX 16'hFFFF
`define PGOWM_CNT_ZERO 16'h0000
`define PGOWM_RST_REG 16'h0000
`define PGOWM_RST_PRM 6'h00
`define PGOWM_RD_ZERO 32'h0000_0000

`endif

//--- rtl/pgowm_pkg.sv
// Types shared by the pulse timer modules
package pgowm_pkg;

   typedef enum logic [1:0] {
      mode_stop,
      mode_free,
      mode_edge_clr,
      mode_match_clr
   } pgowm_mode_t;

   typedef struct packed {
      pgowm_mode_t mode;
      logic ovf;
      logic [2:0] ccc;
      logic oe;
      logic tog_a;
      logic tog_b;
      logic os_en;
      logic [5:0] prm;
      logic [2:0] div;
      logic [15:0] cnt;
      logic [15:0] cra;
      logic [15:0] crb;
      logic level;
      logic pin;
      logic armed;
      logic irq_a;
      logic irq_b;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pgowm_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } pgowm_sync_t;

endpackage

//--- rtl/pgowm_edge.sv
// Two-stage synchroniser and edge detector for one trigger pin
`timescale 1ns/1ps
`default_nettype none

module pgowm_edge (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pin,
   output logic rise,
   output logic fall
);

   pgowm_pkg::pgowm_sync_t q;
   pgowm_pkg::pgowm_sync_t d;

   always_comb begin
      d = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.prev = q.s2;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // First stage feeds only the second
   assign rise = q.s2 & ~q.prev;
   assign fall = ~q.s2 & q.prev;

endmodule

`default_nettype wire

//--- rtl/pgowm_top.sv
// Pulse generator, one-shot and pulse-width timer with APB registers
//
// What this block does
// - Mode field 11 selects pulse generation, counter restarts on compare A match.
// - Free-running counter wraps FFFFH to 0000H and sets the overflow flag.
// - Pulse mode: compare A match raises match A event and clears counter.
// - Pulse mode: compare B match raises match B event, counter keeps running.
// - Pulse period is A+1 count clocks, duty (B+1)/(A+1).
// - One-shot is enabled by mode 01 or 10 plus the one-shot enable bit.
// - Software trigger bit or valid input A edge clears and restarts the counter.
// - Each trigger yields exactly one output pulse, length set by B minus A.
// - In one-shot, either compare match raises its event and, while armed, inverts the output.
// - Trigger to pulse start takes A+1 count clocks.
// - One-shot active level lasts B minus A count clocks.
// - Two-input capture: input A edge captures into B, input B edge into A.
// - One-input capture: reverse A edge captures into A, valid edge into B.
// - Mode 10 capture: reverse edge into A, valid edge into B and clears counter.
// - Reading the counter register returns the current count.
// - Capture A trigger is selectable between input B and input A.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pgowm_defs.svh"

module pgowm_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_input_a,
   input wire logic trigger_input_b,
   output logic pulse_out_pin,
   output logic match_irq_a,
   output logic match_irq_b
);

   pgowm_pkg::pgowm_state_t q;
   pgowm_pkg::pgowm_state_t d;

   logic [1:0] pins;
   logic [1:0] rise;
   logic [1:0] fall;

   assign pins = {trigger_input_b, trigger_input_a};

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_sync
         pgowm_edge u_edge (
            .mclk(mclk),
            .rst_n(rst_n),
            .pin(pins[g]),
            .rise(rise[g]),
            .fall(fall[g])
         );
      end
   endgenerate

   logic setup;
   logic wr;
   logic mapped;
   logic [2:0] div_mask;
   logic tick;
   logic [1:0] esa;
   logic [1:0] esb;
   logic valid_a;
   logic valid_b;
   logic rev_a;
   logic running;
   logic os_mode;
   logic sw_trig;
   logic trig;
   logic match_a;
   logic match_b;
   logic cap_a;
   logic cap_b;
   logic tog;

   assign setup = psel & ~penable;
   // Writes land only at the access edge that the slave accepts
   assign wr = psel & penable & pwrite & q.pready;
   assign mapped = (paddr == `PGOWM_OFF_MODE) | (paddr == `PGOWM_OFF_CCC) |
                   (paddr == `PGOWM_OFF_TOC) | (paddr == `PGOWM_OFF_PRM) |
                   (paddr == `PGOWM_OFF_CNT) | (paddr == `PGOWM_OFF_CRA) |
                   (paddr == `PGOWM_OFF_CRB);

   // Count clock is mclk divided by 1, 2, 4 or 8
   assign div_mask = (q.prm[`PGOWM_PRM_PS_HI:`PGOWM_PRM_PS_LO] == 2'h0) ? 3'h0 :
                     (q.prm[`PGOWM_PRM_PS_HI:`PGOWM_PRM_PS_LO] == 2'h1) ? 3'h1 :
                     (q.prm[`PGOWM_PRM_PS_HI:`PGOWM_PRM_PS_LO] == 2'h2) ? 3'h3 : 3'h7;
   assign tick = ((q.div & div_mask) == div_mask);

   assign esa = q.prm[`PGOWM_PRM_ESA_HI:`PGOWM_PRM_ESA_LO];
   assign esb = q.prm[`PGOWM_PRM_ESB_HI:`PGOWM_PRM_ESB_LO];
   assign valid_a = ((esa == `PGOWM_EDGE_RISE) & rise[0]) |
                    ((esa == `PGOWM_EDGE_FALL) & fall[0]) |
                    ((esa == `PGOWM_EDGE_BOTH) & (rise[0] | fall[0]));
   assign valid_b = ((esb == `PGOWM_EDGE_RISE) & rise[1]) |
                    ((esb == `PGOWM_EDGE_FALL) & fall[1]) |
                    ((esb == `PGOWM_EDGE_BOTH) & (rise[1] | fall[1]));
   // With both edges selected there is no reverse phase
   assign rev_a = ((esa == `PGOWM_EDGE_RISE) & fall[0]) |
                  ((esa == `PGOWM_EDGE_FALL) & rise[0]);

   assign running = (q.mode != pgowm_pkg::mode_stop);
   assign os_mode = q.os_en & ((q.mode == pgowm_pkg::mode_free) |
                               (q.mode == pgowm_pkg::mode_edge_clr));
   assign sw_trig = wr & (paddr == `PGOWM_OFF_TOC) & pwdata[`PGOWM_TOC_OS_TRIG];
   assign trig = os_mode & (sw_trig | valid_a);

   // Matches are evaluated on count clocks only
   assign match_a = running & tick & ~q.ccc[`PGOWM_CCC_CRA_CAP] & (q.cnt == q.cra);
   assign match_b = running & tick & ~q.ccc[`PGOWM_CCC_CRB_CAP] & (q.cnt == q.crb);

   assign cap_b = running & q.ccc[`PGOWM_CCC_CRB_CAP] & valid_a;
   assign cap_a = running & q.ccc[`PGOWM_CCC_CRA_CAP] &
                  (q.ccc[`PGOWM_CCC_CRA_SEL] ? rev_a : valid_b);

   // One-shot toggles only while armed, so a wrap cannot start a second pulse
   assign tog = ((match_a & q.tog_a) ^ (match_b & q.tog_b)) &
                (~os_mode | q.armed);

   always_comb begin
      d = q;
      d.irq_a = 1'b0;
      d.irq_b = 1'b0;
      d.div = q.div + 3'h1;
      d.pready = setup;
      d.pslverr = setup & ~mapped;

      if (setup) begin
         d.prdata = `PGOWM_RD_ZERO;
         case (paddr)
            `PGOWM_OFF_MODE: begin
               d.prdata[`PGOWM_MODE_HI:`PGOWM_MODE_LO] = q.mode;
               d.prdata[`PGOWM_MODE_OVF] = q.ovf;
            end
            `PGOWM_OFF_CCC: d.prdata[`PGOWM_CCC_HI:0] = q.ccc;
            `PGOWM_OFF_TOC: begin
               d.prdata[`PGOWM_TOC_OE] = q.oe;
               d.prdata[`PGOWM_TOC_TOG_A] = q.tog_a;
               d.prdata[`PGOWM_TOC_TOG_B] = q.tog_b;
               d.prdata[`PGOWM_TOC_OS_EN] = q.os_en;
            end
            `PGOWM_OFF_PRM: d.prdata[`PGOWM_PRM_PS_HI:0] = q.prm;
            `PGOWM_OFF_CNT: d.prdata[15:0] = q.cnt;
            `PGOWM_OFF_CRA: d.prdata[15:0] = q.cra;
            `PGOWM_OFF_CRB: d.prdata[15:0] = q.crb;
            default: d.prdata = `PGOWM_RD_ZERO;
         endcase
      end

      if (wr) begin
         case (paddr)
            `PGOWM_OFF_MODE: begin
               d.mode = pgowm_pkg::pgowm_mode_t'(pwdata[`PGOWM_MODE_HI:`PGOWM_MODE_LO]);
               // Writing 0 clears the flag, writing 1 leaves it
               if (!pwdata[`PGOWM_MODE_OVF]) begin
                  d.ovf = 1'b0;
               end
            end
            `PGOWM_OFF_CCC: d.ccc = pwdata[`PGOWM_CCC_HI:0];
            `PGOWM_OFF_TOC: begin
               d.oe = pwdata[`PGOWM_TOC_OE];
               d.tog_a = pwdata[`PGOWM_TOC_TOG_A];
               d.tog_b = pwdata[`PGOWM_TOC_TOG_B];
               d.os_en = pwdata[`PGOWM_TOC_OS_EN];
               // Preset of the output level only while stopped; both set is ignored
               if (!running && (pwdata[`PGOWM_TOC_LVS] != pwdata[`PGOWM_TOC_LVR])) begin
                  d.level = pwdata[`PGOWM_TOC_LVS];
               end
            end
            `PGOWM_OFF_PRM: d.prm = pwdata[`PGOWM_PRM_PS_HI:0];
            `PGOWM_OFF_CRA: d.cra = pwdata[15:0];
            `PGOWM_OFF_CRB: d.crb = pwdata[15:0];
            default: d.prm = q.prm;
         endcase
      end

      if (!running) begin
         d.cnt = `PGOWM_CNT_ZERO;
         d.armed = 1'b0;
      end else if (trig || ((q.mode == pgowm_pkg::mode_edge_clr) && valid_a)) begin
         d.cnt = `PGOWM_CNT_ZERO;
      end else if (tick) begin
         if ((q.mode == pgowm_pkg::mode_match_clr) && match_a) begin
            d.cnt = `PGOWM_CNT_ZERO;
         end else begin
            d.cnt = q.cnt + 16'h0001;
         end
         // Set beats a same-cycle software clear
         if (q.cnt == `PGOWM_CNT_MAX) begin
            d.ovf = 1'b1;
         end
      end

      if (running && os_mode) begin
         if (trig) begin
            d.armed = 1'b1;
         end else if (match_b) begin
            d.armed = 1'b0;
         end
      end else begin
         d.armed = 1'b0;
      end

      if (running && tog) begin
         d.level = ~q.level;
      end

      // Hardware capture wins over a register write in the same cycle
      if (cap_b) begin
         d.crb = q.cnt;
      end
      if (cap_a) begin
         d.cra = q.cnt;
      end

      d.irq_a = match_a | (cap_a & ~q.ccc[`PGOWM_CCC_CRA_SEL]);
      d.irq_b = match_b | cap_b;

      d.pin = d.oe & d.level;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign pulse_out_pin = q.pin;
   assign match_irq_a = q.irq_a;
   assign match_irq_b = q.irq_b;

   // Reset masks every check, so the first edges after release start clean
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   ppg_clear_a: assert property (
      (q.mode == pgowm_pkg::mode_match_clr) && match_a |=> (q.cnt == 16'h0000) && q.irq_a)
      else $error("Pulse mode A match did not clear counter");

   ppg_keep_b: assert property (
      (q.mode == pgowm_pkg::mode_match_clr) && match_b && !match_a
      |=> (q.cnt == $past(q.cnt) + 16'h0001) && q.irq_b)
      else $error("Pulse mode B match disturbed counter");

   wrap_ovf_a: assert property (
      (q.mode == pgowm_pkg::mode_free) && tick && !trig && (q.cnt == 16'hFFFF)
      |=> q.ovf && (q.cnt == 16'h0000))
      else $error("Counter wrap did not set overflow");

   trig_clear_a: assert property (
      running && trig |=> (q.cnt == 16'h0000) && q.armed)
      else $error("Trigger did not restart counter");

   shot_toggle_a: assert property (
      os_mode && running && q.armed && match_a && q.tog_a && !(match_b && q.tog_b)
      |=> (q.level != $past(q.level)))
      else $error("One-shot A match did not invert output");

   shot_end_a: assert property (
      os_mode && running && q.armed && match_b && !trig |=> !q.armed)
      else $error("One-shot stayed armed after pulse end");

   cap_into_b_a: assert property (
      cap_b |=> (q.crb == $past(q.cnt)) && q.irq_b)
      else $error("Input A edge did not capture into B");

   cap_rev_a: assert property (
      running && q.ccc[`PGOWM_CCC_CRA_CAP] && q.ccc[`PGOWM_CCC_CRA_SEL] && rev_a
      |=> (q.cra == $past(q.cnt)) && !q.irq_a)
      else $error("Reverse edge did not capture into A");

   edge_clear_a: assert property (
      (q.mode == pgowm_pkg::mode_edge_clr) && valid_a |=> (q.cnt == 16'h0000))
      else $error("Valid edge did not clear counter");

   cnt_read_a: assert property (
      setup && (paddr == `PGOWM_OFF_CNT) |=> q.pready && (q.prdata[15:0] == $past(q.cnt)))
      else $error("Counter read returned wrong value");

   irq_pulse_a: assert property (
      match_a |=> q.irq_a)
      else $error("Match A event missing");

   ppg_toggle_a: assert property (
      (q.mode == pgowm_pkg::mode_match_clr) && match_a && q.tog_a && !(match_b && q.tog_b)
      |=> (q.level != $past(q.level)))
      else $error("Pulse mode A match did not invert output");

   // Between shots the output must not move, whatever the counter does
   shot_idle_a: assert property (
      running && os_mode && !q.armed && !trig |=> (q.level == $past(q.level)))
      else $error("Output moved while one-shot was idle");

   cap_into_a_a: assert property (
      cap_a && !q.ccc[`PGOWM_CCC_CRA_SEL] |=> (q.cra == $past(q.cnt)) && q.irq_a)
      else $error("Input B edge did not capture into A");

   // A second event one clock later would mean a stuck compare
   irq_single_a: assert property (
      match_b && !wr && !trig && (q.crb != q.cra) &&
      !((q.mode == pgowm_pkg::mode_edge_clr) && valid_a) |=> q.irq_b ##1 !q.irq_b)
      else $error("Match B event wider than one cycle");

   // Main scenarios: pulse period, one shot, both capture paths, overflow

   ppg_cycle_c: cover property (
      (q.mode == pgowm_pkg::mode_match_clr) && match_b ##[1:1000] match_a);

   shot_pulse_c: cover property (
      trig ##[1:1000] (q.armed && match_a) ##[1:1000] (q.armed && match_b));

   cap_by_b_c: cover property (
      cap_a && !q.ccc[`PGOWM_CCC_CRA_SEL] ##1 q.irq_a);

   cap_rev_c: cover property (
      running && q.ccc[`PGOWM_CCC_CRA_SEL] && rev_a ##1 !q.irq_a);

   ovf_wrap_c: cover property (
      tick && running && (q.cnt == 16'hFFFF) ##1 q.ovf);

endmodule

`default_nettype wire

//--- tb/pgowm_src.sv
// Edge sources for both trigger pins and a load that counts pin changes
`timescale 1ns/1ps
`default_nettype none

module pgowm_src (
   input wire logic mclk,
   input wire logic pulse_out_pin,
   output logic trig_a,
   output logic trig_b,
   output var int n_edges
);
   logic last_q;

   // Idle high, so the first fall is a valid edge at reset edge settings
   initial begin
      trig_a = 1'b1;
      trig_b = 1'b1;
      n_edges = 0;
      last_q = 1'b0;
   end

   always @(posedge mclk) begin
      if (pulse_out_pin !== last_q) begin
         n_edges <= n_edges + 1;
      end
      last_q <= pulse_out_pin;
   end

   // Called just after an edge; the next change comes n edges later
   task automatic step_a(input logic v, input int n);
      trig_a <= v;
      repeat (n) @(posedge mclk);
   endtask

   task automatic step_b(input logic v, input int n);
      trig_b <= v;
      repeat (n) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the pulse timer
`timescale 1ns/1ps
`default_nettype none
`include "pgowm_defs.svh"

module tb;
   localparam int PA = 4;
   localparam int PB = 1;
   localparam int OA = 3;
   localparam int OB = 8;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic trig_a, trig_b, pulse_out_pin, match_irq_a, match_irq_b;
   int fail_count, n_checks, na, nb, n_edges;

   pgowm_top i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trigger_input_a(trig_a), .trigger_input_b(trig_b),
      .pulse_out_pin(pulse_out_pin), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));
   pgowm_src i_src (.mclk(mclk), .pulse_out_pin(pulse_out_pin), .trig_a(trig_a),
      .trig_b(trig_b), .n_edges(n_edges));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      na <= na + int'(match_irq_a);
      nb <= nb + int'(match_irq_b);
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         fail_count++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cap_diff(input logic [31:0] exp);
      logic [31:0] c;
      apb(1'b0, `PGOWM_OFF_CRA, 32'h0);
      c = rd;
      apb(1'b0, `PGOWM_OFF_CRB, 32'h0);
      chk(c - rd, exp);
   endtask

   task automatic t_regs;
      for (int a = 0; a <= 'h18; a += 4) begin
         apb(1'b0, 12'(a), 32'h0);
         chk(rd, `PGOWM_RD_ZERO);
      end
      apb(1'b0, 12'h01C, 32'h0);
      chk({31'h0, err}, 32'h0000_0001);
      apb(1'b1, `PGOWM_OFF_CNT, 32'h0000_1234);
      apb(1'b0, `PGOWM_OFF_CNT, 32'h0);
      chk(rd, `PGOWM_RD_ZERO);
      apb(1'b1, `PGOWM_OFF_TOC, 32'h0000_0041);
      apb(1'b0, `PGOWM_OFF_TOC, 32'h0);
      chk(rd, 32'h0000_0001);
      apb(1'b1, `PGOWM_OFF_TOC, 32'h0);
   endtask

   task automatic t_capture;
      logic [31:0] c0;
      int a0, b0;
      apb(1'b1, `PGOWM_OFF_CCC, 32'h0000_0005);
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0000_0004);
      apb(1'b0, `PGOWM_OFF_CNT, 32'h0);
      c0 = rd;
      apb(1'b0, `PGOWM_OFF_CNT, 32'h0);
      // Setup edges of two back-to-back reads lie three clocks apart
      chk(rd - c0, 32'h0000_0003);
      a0 = na;
      b0 = nb;
      i_src.step_a(1'b0, 10);
      i_src.step_b(1'b0, 10);
      i_src.step_a(1'b1, 1);
      i_src.step_b(1'b1, 10);
      chk(32'(na - a0), 32'h0000_0001);
      chk(32'(nb - b0), 32'h0000_0001);
      cap_diff(32'h0000_000A);
      apb(1'b1, `PGOWM_OFF_CCC, 32'h0000_0007);
      i_src.step_a(1'b0, 10);
      i_src.step_a(1'b1, 10);
      cap_diff(32'h0000_000A);
      chk(32'(na - a0), 32'h0000_0001);
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0000_0008);
      i_src.step_a(1'b0, 7);
      i_src.step_a(1'b1, 13);
      i_src.step_a(1'b0, 10);
      apb(1'b0, `PGOWM_OFF_CRA, 32'h0);
      chk(rd, 32'h0000_0006);
      apb(1'b0, `PGOWM_OFF_CRB, 32'h0);
      chk(rd, 32'h0000_0013);
      i_src.step_a(1'b1, 5);
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0);
      apb(1'b1, `PGOWM_OFF_CCC, 32'h0);
   endtask

   task automatic t_ppg;
      logic [4:0] va, vb, vp;
      logic p;
      int k;
      apb(1'b1, `PGOWM_OFF_CRA, 32'(PA));
      apb(1'b1, `PGOWM_OFF_CRB, 32'(PB));
      apb(1'b1, `PGOWM_OFF_TOC, 32'h0000_0013);
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0000_000C);
      k = 0;
      do begin
         @(posedge mclk);
         #1;
         k++;
      end while (match_irq_a !== 1'b1 && k < 40);
      p = pulse_out_pin;
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk);
         #1;
         va[i] = match_irq_a;
         vb[i] = match_irq_b;
         vp[i] = pulse_out_pin ^ p;
      end
      chk(32'(va), 32'(1 << PA));
      chk(32'(vb), 32'(1 << PB));
      chk(32'(vp), 32'((1 << PA) - (1 << PB)));
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0);
   endtask

   // Judges one one-shot pulse; a negative delay is not judged
   task automatic pulse(input int dly);
      int k, w, a0, b0, e0;
      logic p;
      a0 = na;
      b0 = nb;
      p = pulse_out_pin;
      k = 0;
      w = 0;
      do begin
         @(posedge mclk);
         #1;
         k++;
      end while (pulse_out_pin === p && k < 40);
      if (dly >= 0) begin
         chk(32'(k), 32'(dly));
      end
      do begin
         @(posedge mclk);
         #1;
         w++;
      end while (pulse_out_pin !== p && w < 40);
      chk(32'(w), 32'(OB - OA));
      // The load counts the closing edge one clock late
      @(posedge mclk);
      #1;
      e0 = n_edges;
      repeat (30) @(posedge mclk);
      chk(32'(n_edges - e0), 32'h0);
      chk(32'(na - a0), 32'h0000_0001);
      chk(32'(nb - b0), 32'h0000_0001);
   endtask

   task automatic t_oneshot;
      apb(1'b1, `PGOWM_OFF_CRA, 32'(OA));
      apb(1'b1, `PGOWM_OFF_CRB, 32'(OB));
      apb(1'b1, `PGOWM_OFF_TOC, 32'h0000_0033);
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0000_0004);
      repeat (12) @(posedge mclk);
      apb(1'b1, `PGOWM_OFF_TOC, 32'h0000_0073);
      pulse(OA + 1);
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0000_0008);
      repeat (12) @(posedge mclk);
      i_src.step_a(1'b0, 0);
      // Pin synchroniser and edge stage add three clocks
      pulse(OA + 4);
      i_src.step_a(1'b1, 2);
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0);
   endtask

   // One wrap serves both the free-running flag and the long period capture
   task automatic t_ovf;
      apb(1'b1, `PGOWM_OFF_TOC, 32'h0);
      apb(1'b1, `PGOWM_OFF_CCC, 32'h0000_0004);
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0000_0008);
      i_src.step_a(1'b0, 10);
      i_src.step_a(1'b1, 65000);
      // Free-running before the count reaches its top
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0000_0004);
      repeat (600) @(posedge mclk);
      apb(1'b0, `PGOWM_OFF_MODE, 32'h0);
      chk(rd, 32'h0000_0005);
      // Back to clear on valid edge, flag kept by writing 1
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0000_0009);
      i_src.step_a(1'b0, 10);
      apb(1'b0, `PGOWM_OFF_MODE, 32'h0);
      chk(rd, 32'h0000_0009);
      // Falls 65619 clocks apart; capture holds the count before the clear
      apb(1'b0, `PGOWM_OFF_CRB, 32'h0);
      chk(rd + 32'h0001_0000, 32'h0001_0052);
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0000_0008);
      apb(1'b0, `PGOWM_OFF_MODE, 32'h0);
      chk(rd, 32'h0000_0008);
      apb(1'b1, `PGOWM_OFF_MODE, 32'h0);
   endtask

   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #1_600_000;
      fail_count++;
      complete_run();
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fail_count = 0;
      n_checks = 0;
      na = 0;
      nb = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_capture();
      t_ppg();
      t_oneshot();
      t_ovf();
      complete_run();
   end
endmodule
`default_nettype wire
